/* File: verilog/uspc_pkg.sv */
`default_nettype none
package uspc_pkg;
    // ----------------------------------------------------------------
    // Register byte addresses
    // ----------------------------------------------------------------
    localparam logic [7:0] ADR_FUNC   = 8'h00;
    localparam logic [7:0] ADR_DIR    = 8'h04;
    localparam logic [7:0] ADR_SET    = 8'h08;
    localparam logic [7:0] ADR_CLR    = 8'h0C;
    localparam logic [7:0] ADR_STAT   = 8'h10;
    localparam logic [7:0] ADR_MASK   = 8'h14;
    localparam logic [7:0] ADR_FMT    = 8'h18;
    localparam logic [7:0] ADR_DELAY  = 8'h1C;
    localparam logic [7:0] ADR_NTFY   = 8'h20;
    // ----------------------------------------------------------------
    // Field layout and reset values
    // ----------------------------------------------------------------
    localparam int         NPIN       = 6;
    localparam int         POL_BIT    = 3;
    localparam logic [2:0] MODE_RST   = 3'h0;
    localparam logic [5:0] PIN_RST    = 6'h00;
    localparam logic [5:0] MASK_RST   = 6'h00;
    localparam logic [3:0] DELAY_RST  = 4'h0;
    localparam logic [3:0] LAST_BYTE  = 4'h9;
    // Pin function select codes
    typedef enum logic [2:0] {
        FN_GPIO   = 3'b000,
        FN_RTSCTS = 3'b001,
        FN_DTRDSR = 3'b010,
        FN_XCVR   = 3'b011,
        FN_XCVR_M = 3'b100
    } uspc_fn_t;
    // ----------------------------------------------------------------
    // Notification packet constants
    // ----------------------------------------------------------------
    localparam logic [7:0] REQ_TYPE   = 8'hA1;
    localparam logic [7:0] NTF_SERIAL = 8'h20;
    localparam logic [7:0] LEN_LO     = 8'h02;
    localparam logic [7:0] ZERO_BYTE  = 8'h00;
    typedef enum logic [0:0] {
        NS_IDLE = 1'b0,
        NS_SEND = 1'b1
    } uspc_nstate_t;
endpackage
`default_nettype wire

/* File: verilog/uspc_notify.sv */
// How it works
// - Select 000 leaves all six pins as plain software pins.
// - Select 001 makes pin 4 clear-to-send in, pin 5 request-to-send out.
// - Select 010 makes pin 2 data-set-ready in, pin 3 terminal-ready out.
// - Select 011 drives pin 5 as the transceiver direction output.
// - Select 100 drives pin 5 direction only after an address match.
// - Polarity 0 drives direction low while sending, polarity 1 high.
// - Direction bit 0 makes a pin an input, 1 a driven output.
// - Pins taken by an alternate function are not driven or read via direction.
// - Output-set write drives each output high for 1, low for 0.
// - Output-set writes leave pins configured as inputs untouched.
// - Output-clear write drives low each pin written 1, others unchanged.
// - Status register returns the present level of every pin.
// - A pin change raises a notification only when its mask bit is 0.
// - Masked pins still show in status and in any extended-format notification packet.
// - Format bit 0 gives standard data, 1 the extended pin layout.
// - Packet is A1, 20, value 0, index 0, length 2, two data bytes.
// - Data D6..D0 carry overrun, parity, framing, ring, break, DSR, CD.
// - Extended data puts pins 5,4,3,0,2,1 at D14,13,12,11,9,8.
// - Direction output drops only after the programmed bit-time delay.
//
// The Wishbone register port and the register offsets were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module uspc_notify
    import uspc_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic [5:0]  pin_i,
    output logic      [5:0]  pin_o,
    output logic      [5:0]  pin_oe_o,
    input  wire logic        tx_active_i,
    input  wire logic        addr_match_i,
    input  wire logic        bit_tick_i,
    input  wire logic        rts_n_i,
    input  wire logic        dtr_n_i,
    output logic             cts_n_o,
    output logic             dsr_n_o,
    input  wire logic [6:0]  line_status_i,
    input  wire logic        line_event_i,
    output logic             ntf_valid_o,
    output logic      [7:0]  ntf_data_o,
    output logic             ntf_last_o,
    input  wire logic        ntf_ready_i
);
    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    logic [2:0]   mode_q;
    logic         pol_q;
    logic [5:0]   dir_q;
    logic [5:0]   out_q;
    logic [5:0]   mask_q;
    logic         fmt_q;
    logic [3:0]   delay_q;
    logic [5:0]   pin_q;
    logic [5:0]   prev_q;
    logic [3:0]   hold_q;
    logic         pend_q;
    uspc_nstate_t ns_q;
    logic [3:0]   idx_q;
    logic [15:0]  word_q;
    logic [5:0]   alt_w;
    logic [5:0]   drv_w;
    logic [5:0]   val_w;
    logic [5:0]   chg_w;
    logic         req_w;
    logic         wr_w;
    logic         xcvr_w;
    logic         dir_on_w;
    logic         start_w;
    logic [15:0]  data_w;
    logic [31:0]  rd_w;

    // ----------------------------------------------------------------
    // Wishbone slave
    // ----------------------------------------------------------------
    // A request is taken once; ack is high in the following cycle only
    assign req_w = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_w  = req_w && wb_we_i && wb_sel_i[0];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req_w;
        end
    end

    // Read mux; unmapped addresses read zero and still ack
    always_comb begin
        rd_w = '0;
        if (wb_adr_i == ADR_FUNC) begin
            rd_w[3:0] = {pol_q, mode_q};
        end else if (wb_adr_i == ADR_DIR) begin
            rd_w[5:0] = dir_q & ~alt_w;
        end else if (wb_adr_i == ADR_SET) begin
            rd_w[5:0] = out_q;
        end else if (wb_adr_i == ADR_STAT) begin
            rd_w[5:0] = pin_q;
        end else if (wb_adr_i == ADR_MASK) begin
            rd_w[5:0] = mask_q;
        end else if (wb_adr_i == ADR_FMT) begin
            rd_w[0] = fmt_q;
        end else if (wb_adr_i == ADR_DELAY) begin
            rd_w[3:0] = delay_q;
        end else if (wb_adr_i == ADR_NTFY) begin
            rd_w[1:0] = {ns_q == NS_SEND, pend_q};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= '0;
        end else if (req_w && !wb_we_i) begin
            wb_dat_o <= rd_w;
        end
    end

    // Configuration registers; upper select bits are not stored
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_q  <= MODE_RST;
            pol_q   <= 1'b0;
            dir_q   <= PIN_RST;
            mask_q  <= MASK_RST;
            fmt_q   <= 1'b0;
            delay_q <= DELAY_RST;
        end else if (wr_w) begin
            if (wb_adr_i == ADR_FUNC) begin
                mode_q <= wb_dat_i[2:0];
                pol_q  <= wb_dat_i[POL_BIT];
            end else if (wb_adr_i == ADR_DIR) begin
                dir_q <= wb_dat_i[5:0];
            end else if (wb_adr_i == ADR_MASK) begin
                mask_q <= wb_dat_i[5:0];
            end else if (wb_adr_i == ADR_FMT) begin
                fmt_q <= wb_dat_i[0];
            end else if (wb_adr_i == ADR_DELAY) begin
                delay_q <= wb_dat_i[3:0];
            end
        end
    end

    // Output latch: set writes only reach pins set as outputs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_q <= PIN_RST;
        end else if (wr_w && wb_adr_i == ADR_SET) begin
            out_q <= (wb_dat_i[5:0] & dir_q) | (out_q & ~dir_q);
        end else if (wr_w && wb_adr_i == ADR_CLR) begin
            out_q <= out_q & ~wb_dat_i[5:0];
        end
    end

    // ----------------------------------------------------------------
    // Pin function select
    // ----------------------------------------------------------------
    // Codes 101 to 111 are undefined and fall back to plain pins
    always_comb begin
        alt_w = '0;
        case (mode_q)
            FN_RTSCTS: alt_w = 6'h30;
            FN_DTRDSR: alt_w = 6'h0C;
            FN_XCVR:   alt_w = 6'h20;
            FN_XCVR_M: alt_w = 6'h20;
            default:   alt_w = '0;
        endcase
    end

    // Transceiver direction; mode 100 also waits for an address match
    assign xcvr_w = (mode_q == FN_XCVR_M) ? (tx_active_i && addr_match_i)
                                          : tx_active_i;

    // Hold the direction on for the turn-around delay after sending
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hold_q <= DELAY_RST;
        end else if (xcvr_w) begin
            hold_q <= delay_q;
        end else if (bit_tick_i && hold_q != DELAY_RST) begin
            hold_q <= hold_q - 4'h1;
        end
    end

    assign dir_on_w = xcvr_w || (hold_q != DELAY_RST);

    // Per-pin drive: alternate function wins over software direction
    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++) begin : g_pin
            logic av;
            logic ad;
            always_comb begin
                av = 1'b0;
                ad = 1'b0;
                if (gi == 5 && mode_q == FN_RTSCTS) begin
                    ad = 1'b1;
                    av = rts_n_i;
                end else if (gi == 3 && mode_q == FN_DTRDSR) begin
                    ad = 1'b1;
                    av = dtr_n_i;
                end else if (gi == 5) begin
                    ad = 1'b1;
                    av = pol_q ? dir_on_w : !dir_on_w;
                end
            end
            assign drv_w[gi] = alt_w[gi] ? ad : dir_q[gi];
            assign val_w[gi] = alt_w[gi] ? av : out_q[gi];
        end
    endgenerate

    // Pin outputs are registered to keep glitches off the pads
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_o    <= PIN_RST;
            pin_oe_o <= PIN_RST;
        end else begin
            pin_o    <= val_w;
            pin_oe_o <= drv_w;
        end
    end

    // Flow-control inputs idle high (inactive) when not selected
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cts_n_o <= 1'b1;
            dsr_n_o <= 1'b1;
        end else begin
            cts_n_o <= (mode_q == FN_RTSCTS) ? pin_i[4] : 1'b1;
            dsr_n_o <= (mode_q == FN_DTRDSR) ? pin_i[2] : 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Change detection and notification packet
    // ----------------------------------------------------------------
    // Two samples compared every cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_q  <= PIN_RST;
            prev_q <= PIN_RST;
        end else begin
            pin_q  <= pin_i;
            prev_q <= pin_q;
        end
    end

    assign chg_w   = (pin_q ^ prev_q) & ~mask_q;
    assign start_w = (ns_q == NS_IDLE) && pend_q;

    // Pending flag: a new event in the start cycle is kept
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pend_q <= 1'b0;
        end else if (chg_w != '0 || line_event_i) begin
            pend_q <= 1'b1;
        end else if (start_w) begin
            pend_q <= 1'b0;
        end
    end

    // In extended format the data word carries every pin's level whatever its mask
    always_comb begin
        data_w      = '0;
        data_w[6:0] = line_status_i;
        if (fmt_q) begin
            data_w[14:11] = {pin_q[5], pin_q[4], pin_q[3], pin_q[0]};
            data_w[9:8]   = {pin_q[2], pin_q[1]};
        end
    end

    // Byte order of the packet, little endian fields
    function automatic logic [7:0] pkt_byte(input logic [3:0] i,
                                            input logic [15:0] w);
        logic [7:0] b;
        b = ZERO_BYTE;
        case (i)
            4'h0:    b = REQ_TYPE;
            4'h1:    b = NTF_SERIAL;
            4'h6:    b = LEN_LO;
            4'h8:    b = w[7:0];
            4'h9:    b = w[15:8];
            default: b = ZERO_BYTE;
        endcase
        return b;
    endfunction

    // Sender: one byte stands until the endpoint takes it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ns_q        <= NS_IDLE;
            idx_q       <= '0;
            word_q      <= '0;
            ntf_valid_o <= 1'b0;
            ntf_data_o  <= '0;
            ntf_last_o  <= 1'b0;
        end else begin
            case (ns_q)
                NS_IDLE: begin
                    if (pend_q) begin
                        ns_q        <= NS_SEND;
                        idx_q       <= '0;
                        word_q      <= data_w;
                        ntf_valid_o <= 1'b1;
                        ntf_data_o  <= pkt_byte(4'h0, data_w);
                        ntf_last_o  <= 1'b0;
                    end
                end
                NS_SEND: begin
                    if (ntf_ready_i) begin
                        if (idx_q == LAST_BYTE) begin
                            ns_q        <= NS_IDLE;
                            ntf_valid_o <= 1'b0;
                            ntf_last_o  <= 1'b0;
                        end else begin
                            idx_q       <= idx_q + 4'h1;
                            ntf_data_o  <= pkt_byte(idx_q + 4'h1, word_q);
                            ntf_last_o  <= (idx_q + 4'h1) == LAST_BYTE;
                        end
                    end
                end
                default: ns_q <= NS_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held more than one cycle");
    set_input_a: assert property (wr_w && wb_adr_i == ADR_SET && !dir_q[0]
        |=> out_q[0] == $past(out_q[0]))
        else $error("set write changed an input pin");
    set_drive_a: assert property (wr_w && wb_adr_i == ADR_SET && dir_q[1]
        |=> out_q[1] == $past(wb_dat_i[1]))
        else $error("set write not applied");
    clr_low_a: assert property (wr_w && wb_adr_i == ADR_CLR && wb_dat_i[2]
        |=> !out_q[2])
        else $error("clear write did not drive low");
    dir_read_a: assert property (req_w && !wb_we_i && wb_adr_i == ADR_DIR
        && mode_q == FN_RTSCTS |=> wb_dat_o[5:4] == 2'b00)
        else $error("alternate pin shown in direction");
    xcvr_pol_a: assert property (mode_q == FN_XCVR && tx_active_i
        |=> pin_o[5] == $past(pol_q) && pin_oe_o[5])
        else $error("direction output level wrong");
    hold_on_a: assert property (mode_q == FN_XCVR && hold_q != DELAY_RST
        |=> pin_o[5] == $past(pol_q))
        else $error("direction dropped before delay");
    masked_a: assert property (ns_q == NS_IDLE && !pend_q && !line_event_i
        && chg_w == '0 |=> !pend_q)
        else $error("masked change raised notification");
    unmask_a: assert property (chg_w != '0 |=> pend_q || ns_q == NS_SEND)
        else $error("unmasked change lost");
    hdr_a: assert property (start_w |=> ntf_valid_o && ntf_data_o == REQ_TYPE)
        else $error("packet header byte wrong");
    pkt_len_a: assert property (ntf_valid_o && ntf_last_o |-> idx_q == LAST_BYTE)
        else $error("packet length not ten bytes");

    pkt_done_c: cover property (ntf_valid_o && ntf_ready_i && ntf_last_o);
    ext_pkt_c:  cover property (start_w && fmt_q);
    hold_c:     cover property (!xcvr_w && hold_q != DELAY_RST && bit_tick_i);
    flow_c:     cover property (mode_q == FN_DTRDSR && pin_oe_o[3]);
endmodule
`default_nettype wire

/* File: bench/uspc_ep_model.sv */
`timescale 1ns/1ns
`default_nettype none
// Interrupt endpoint sink standing in for the host side of the stream
module uspc_ep_model (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        stall_i,
    input  wire logic        valid_i,
    input  wire logic [7:0]  data_i,
    input  wire logic        last_i,
    output logic             ready_o,
    output logic      [79:0] pkt_o,
    output logic      [7:0]  npkt_o,
    output logic             bad_o
);
    logic [3:0] idx_q;
    // ----------------------------------------------------------------
    // Endpoint behaviour
    // ----------------------------------------------------------------
    // Stalling halves the take rate so each byte must stand until taken
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ready_o <= 1'b0;
        end else begin
            ready_o <= stall_i ? !ready_o : 1'b1;
        end
    end
    // Collect bytes; the end marker must sit on the tenth byte
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            idx_q  <= 4'h0;
            npkt_o <= 8'h00;
            bad_o  <= 1'b0;
            pkt_o  <= '0;
        end else if (valid_i && ready_o) begin
            pkt_o[idx_q*8 +: 8] <= data_i;
            if (last_i != (idx_q == 4'h9)) begin
                bad_o <= 1'b1;
            end
            idx_q <= last_i ? 4'h0 : idx_q + 4'h1;
            if (last_i) begin
                npkt_o <= npkt_o + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

/* File: bench/usb_uart_pin_control_and_notify_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module usb_uart_pin_control_and_notify_tb;
    import uspc_pkg::*;
    logic        clk, rst, cyc, stb, we, ack, tx_q, match_q, tick_q;
    logic        rts_q, dtr_q, ev_q, stall_q, cts, dsr, nv, nl, nr, bad;
    logic [7:0]  adr, nd, npkt, n;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat, q;
    logic [5:0]  ext_q, po, oe, pin_w;
    logic [6:0]  ls;
    logic [79:0] pkt;
    int          error_cnt, check_count;
    // Two-way pin level: the driver wins where enabled, else the far side
    assign pin_w = (oe & po) | (~oe & ext_q);
    always #5 clk = ~clk;
    uspc_notify u_uspc_notify (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .pin_i(pin_w), .pin_o(po), .pin_oe_o(oe), .tx_active_i(tx_q),
        .addr_match_i(match_q), .bit_tick_i(tick_q), .rts_n_i(rts_q), .dtr_n_i(dtr_q),
        .cts_n_o(cts), .dsr_n_o(dsr), .line_status_i(ls), .line_event_i(ev_q),
        .ntf_valid_o(nv), .ntf_data_o(nd), .ntf_last_o(nl), .ntf_ready_i(nr));
    uspc_ep_model u_uspc_ep_model (.clk_i(clk), .rst_i(rst), .stall_i(stall_q),
        .valid_i(nv), .data_i(nd), .last_i(nl), .ready_o(nr), .pkt_o(pkt),
        .npkt_o(npkt), .bad_o(bad));
    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic end_of_test;
        $display("checks=%0d errors=%0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Classic cycle: hold everything until ack is sampled high
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        int i;
        @(posedge clk);
        {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, s};
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (ack !== 1'b1 && i < 20);
        q = rdat;
        if (ack !== 1'b1) begin
            error_cnt++;
            end_of_test();
        end
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    // Pins are registered once more after the write lands, so wait one cycle
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hF);
        tk(1);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000, 4'hF);
        chk(q, e);
    endtask
    task automatic tk(input int c);
        repeat (c) @(posedge clk);
    endtask
    // One-cycle strobe: line event when ev is set, else a bit-time tick
    task automatic pulse(input logic ev);
        @(posedge clk);
        if (ev) begin
            ev_q <= 1'b1;
        end else begin
            tick_q <= 1'b1;
        end
        @(posedge clk);
        {ev_q, tick_q} <= 2'b00;
    endtask
    // Bounded wait for the endpoint to complete packet number c
    task automatic wait_pkt(input logic [7:0] c);
        int i;
        i = 0;
        while (npkt !== c && i < 300) begin
            @(posedge clk);
            i++;
        end
        chk(npkt, c);
    endtask
    task automatic pchk(input logic [15:0] d);
        chk(pkt[31:0], 32'h0000_20A1);
        chk(pkt[63:32], 32'h0002_0000);
        chk(pkt[79:64], d);
    endtask
    function automatic logic [15:0] ew(input logic [5:0] p, input logic [6:0] l);
        ew = {1'b0, p[5], p[4], p[3], p[0], 1'b0, p[2], p[1], 1'b0, l};
    endfunction
    // Hang guard
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        end_of_test();
    end
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        {clk, cyc, stb, we, tx_q, match_q, tick_q, rts_q, dtr_q, ev_q, stall_q} = '0;
        {adr, sel, wdat, ext_q} = '0;
        ls = 7'h55;
        rst = 1'b1;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rc(ADR_FUNC, 32'h0000_0000);
        rc(ADR_DIR, 32'h0000_0000);
        rc(ADR_STAT, 32'h0000_0000);
        rc(8'h3C, 32'h0000_0000);
        wr(ADR_MASK, 32'h0000_003F);
        wr(ADR_DIR, 32'h0000_003F);
        chk(oe, 6'h3F);
        wr(ADR_SET, 32'h0000_0015);
        chk(po, 6'h15);
        wr(ADR_CLR, 32'h0000_0001);
        chk(po, 6'h14);
        wr(ADR_DIR, 32'h0000_000F);
        wr(ADR_SET, 32'h0000_003F);
        chk(po, 6'h1F);
        ext_q <= 6'h2A;
        tk(3);
        rc(ADR_STAT, 32'h0000_002F);
        wr(ADR_DIR, 32'h0000_0000);
        bus(1'b1, ADR_DIR, 32'h0000_003F, 4'hE);
        tk(1);
        chk(oe, 6'h00);
        // Flow control pin pairs
        ext_q <= 6'h00;
        wr(ADR_FUNC, 32'h0000_0001);
        wr(ADR_DIR, 32'h0000_003F);
        rc(ADR_DIR, 32'h0000_000F);
        chk(oe, 6'h2F);
        chk({cts, po[5]}, 2'b00);
        rts_q <= 1'b1;
        ext_q <= 6'h10;
        tk(3);
        chk({cts, po[5]}, 2'b11);
        wr(ADR_FUNC, 32'h0000_0002);
        rc(ADR_DIR, 32'h0000_0033);
        ext_q <= 6'h00;
        tk(3);
        chk({oe, po[3], dsr, cts}, 9'h1D9);
        dtr_q <= 1'b1;
        ext_q <= 6'h04;
        tk(3);
        chk({po[3], dsr}, 2'b11);
        // Transceiver direction output, both polarities
        wr(ADR_DIR, 32'h0000_0000);
        wr(ADR_FUNC, 32'h0000_0003);
        tx_q <= 1'b1;
        tk(3);
        chk({oe[5], po[5]}, 2'b10);
        tx_q <= 1'b0;
        tk(3);
        chk(po[5], 1'b1);
        wr(ADR_FUNC, 32'h0000_000C);
        tx_q <= 1'b1;
        tk(3);
        chk(po[5], 1'b0);
        match_q <= 1'b1;
        tk(3);
        chk(po[5], 1'b1);
        {tx_q, match_q} <= 2'b00;
        wr(ADR_DELAY, 32'h0000_0002);
        wr(ADR_FUNC, 32'h0000_000B);
        tx_q <= 1'b1;
        tk(3);
        tx_q <= 1'b0;
        tk(4);
        chk(po[5], 1'b1);
        pulse(1'b0);
        tk(3);
        chk(po[5], 1'b1);
        pulse(1'b0);
        tk(3);
        chk(po[5], 1'b0);
        // Notifications: unmasked change, masked change, other trigger
        wr(ADR_FUNC, 32'h0000_0000);
        ext_q <= 6'h00;
        tk(3);
        rc(ADR_NTFY, 32'h0000_0000);
        wr(ADR_MASK, 32'h0000_003E);
        n = npkt;
        ext_q <= 6'h01;
        wait_pkt(n + 8'h01);
        pchk({9'h000, ls});
        ext_q <= 6'h03;
        tk(40);
        chk(npkt, n + 8'h01);
        wr(ADR_MASK, 32'h0000_003F);
        wr(ADR_FMT, 32'h0000_0001);
        ext_q <= 6'h2D;
        tk(3);
        stall_q <= 1'b1;
        pulse(1'b1);
        wait_pkt(n + 8'h02);
        pchk(ew(6'h2D, ls));
        rc(ADR_STAT, 32'h0000_002D);
        chk(bad, 1'b0);
        end_of_test();
    end
endmodule
`default_nettype wire
